// ---- core/adc_request_sequencer.sv ----
// request sequencing, timing and result handling for one converter
// assumes an external comparator pin and a single system clock
//
// Functional notes
// R1: 10-bit results, optional faster 8-bit mode
// R2: sample and step times set by inputs
// R3: parallel mask converted lowest channel first
// R4: queue converts in software entry order
// R5: single inserted conversion, sequence resumes unchanged
// R6: highest priority pending source starts first
// R7: software, internal and external triggers
// R8: eight result registers, optional FIFO chaining
// R9: wait-for-read stalls instead of overwriting
// R10: limit checking or accumulation reduces results
// R11: master start also starts slave together
// R12: external multiplexer select steps automatically
// R13: nine inputs, two shared with other converter
// R14: per-pin digital input disable
// R15: auto power-down while idle
// R16: broken-wire and multiplexer test reporting
// R17: result event for the transfer controller
// R18: valid set on write, cleared on read
`timescale 1ns/1ns
`default_nettype none
module adc_request_sequencer (
   input  wire logic                      clock,
   input  wire logic                      rstn,
   input  wire logic                      clk_en,
   input  wire logic                      res8_mode,
   input  wire logic [adc_pkg::CNT_W-1:0] sample_cycles,
   input  wire logic [adc_pkg::CNT_W-1:0] step_cycles,
   input  wire logic                      sw_trig,
   input  wire logic                      int_evt,
   input  wire logic                      ext_trig_pin,
   input  wire logic [1:0]                trig_sel,
   input  wire logic [adc_pkg::NUM_CH-1:0] par_mask,
   input  wire logic                      q_wr,
   input  wire logic [adc_pkg::CH_W-1:0]  q_ch,
   input  wire logic                      ins_req,
   input  wire logic [adc_pkg::CH_W-1:0]  ins_ch,
   input  wire logic [1:0]                prio_ins,
   input  wire logic [1:0]                prio_par,
   input  wire logic [1:0]                prio_que,
   input  wire logic                      sync_master,
   input  wire logic                      sync_slave,
   input  wire logic                      sync_start_in,
   input  wire logic [adc_pkg::CH_W-1:0]  slave_ch,
   input  wire logic                      emux_en,
   input  wire logic [adc_pkg::CH_W-1:0]  emux_ch,
   input  wire logic [2:0]                emux_last,
   input  wire logic [adc_pkg::NUM_CH-1:0] pin_in,
   input  wire logic [adc_pkg::NUM_CH-1:0] dig_dis,
   input  wire logic                      cmp_pin,
   input  wire logic                      bwd_en,
   input  wire logic                      mux_test,
   input  wire logic                      chain_en,
   input  wire logic [adc_pkg::NUM_RES-1:0] wfr_mask,
   input  wire logic                      lim_en,
   input  wire logic [adc_pkg::RES_W-1:0] lim_lo,
   input  wire logic [adc_pkg::RES_W-1:0] lim_hi,
   input  wire logic                      acc_en,
   input  wire logic [1:0]                acc_num,
   input  wire logic                      rd_en,
   input  wire logic [adc_pkg::IDX_W-1:0] rd_idx,
   output logic                           q_full,
   output logic                           busy,
   output logic                           powered,
   output logic                           sample_en,
   output logic [adc_pkg::RES_W-1:0]      dac_code,
   output logic [adc_pkg::CH_W-1:0]       ana_sel,
   output logic                           shared_active,
   output logic                           sync_start_out,
   output logic [2:0]                     emux_sel,
   output logic [adc_pkg::NUM_CH-1:0]     dig_in,
   output logic                           bwd_precharge,
   output logic [adc_pkg::NUM_CH-1:0]     broken_wire,
   output logic                           mux_fault,
   output logic                           result_evt,
   output logic                           limit_hit,
   output logic                           stalled,
   output logic [adc_pkg::WORD_W-1:0]     rd_data,
   output logic                           rd_valid,
   output logic [adc_pkg::NUM_RES-1:0]    res_valid
);
   import adc_pkg::*;

   seq_state_e       state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CH_W-1:0]  ch_r;
   logic [RES_W-1:0] sar_r;
   logic [RES_W-1:0] bit_r;
   logic [NUM_CH+1:0] pins_s;
   logic [NUM_CH-1:0] pin_s;
   logic             cmp_s;
   logic             ext_s;
   logic             ext_d_r;
   logic             trig;
   logic [NUM_CH-1:0] par_pend_r;
   logic             ins_pend_r;
   logic [CH_W-1:0]  ins_ch_r;
   logic [CH_W-1:0]  que_r [Q_DEPTH];
   logic [QP_W-1:0]  q_wp_r;
   logic [QP_W-1:0]  q_rp_r;
   logic [QP_W:0]    q_cnt_r;
   src_e             src;
   logic [CH_W-1:0]  src_ch;
   logic             start;
   logic [CH_W-1:0]  start_ch;
   logic             q_push;
   logic             q_pop;
   logic [RES_W-1:0] res_val;
   logic [ACC_W-1:0] acc_sum_r;
   logic [1:0]       acc_cnt_r;
   logic [ACC_W-1:0] sum;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] wp_r;
   logic [IDX_W-1:0] rp_r;
   logic [IDX_W-1:0] mem_rd_idx;
   logic             blocked;
   logic             finish;
   logic             acc_hold;
   logic             lim_out;
   logic             do_write;
   logic             do_read;

   // lowest set channel of a request mask
   function automatic logic [CH_W-1:0] first_set(
      input logic [NUM_CH-1:0] m);
      logic [CH_W-1:0] f;
      f = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (m[i]) f = CH_W'(i);
      end
      return f;
   endfunction : first_set

   // one-hot decode of a channel number
   function automatic logic [NUM_CH-1:0] ch_bit(input logic [CH_W-1:0] c);
      logic [NUM_CH-1:0] b;
      b = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (c == CH_W'(i)) b[i] = 1'b1;
      end
      return b;
   endfunction : ch_bit

   // pins, external trigger and comparator cross into the clock domain
   sync2 #(.WIDTH(NUM_CH + 2)) u_sync (
      .clock    (clock),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .async_in ({cmp_pin, ext_trig_pin, pin_in}),
      .sync_out (pins_s)
   );
   assign pin_s = pins_s[NUM_CH-1:0];
   assign ext_s = pins_s[NUM_CH];
   assign cmp_s = pins_s[NUM_CH+1];

   // digital input stage, gated off per pin
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_dig
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) dig_in[g] <= 1'b0;
            else if (clk_en) dig_in[g] <= pin_s[g] & ~dig_dis[g]; // R14
         end
      end
   endgenerate

   // trigger sources for the parallel request
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) ext_d_r <= 1'b0;
      else if (clk_en) ext_d_r <= ext_s;
   end
   assign trig = sw_trig | (trig_sel[0] & int_evt)
               | (trig_sel[1] & ext_s & ~ext_d_r); // R7

   // arbitration among pending sources, ties go insert, parallel, queue
   always_comb begin
      src    = SRC_NONE;
      src_ch = '0;
      if (ins_pend_r) begin
         src    = SRC_INS;
         src_ch = ins_ch_r;
      end
      if (|par_pend_r && (src == SRC_NONE || prio_par > prio_ins)) begin
         src    = SRC_PAR;
         src_ch = first_set(par_pend_r); // R3
      end
      if (q_cnt_r != '0 && (src == SRC_NONE
          || (src == SRC_INS && prio_que > prio_ins)
          || (src == SRC_PAR && prio_que > prio_par))) begin // R6
         src    = SRC_QUE;
         src_ch = que_r[q_rp_r]; // R4
      end
   end

   // slave starts only with the master's pulse
   assign start = (state_r == ST_IDLE)
                & (sync_slave ? sync_start_in : (src != SRC_NONE)); // R11
   assign start_ch = sync_slave ? slave_ch : src_ch;
   assign q_push = q_wr & (q_cnt_r != (QP_W + 1)'(Q_DEPTH));
   assign q_pop  = start & ~sync_slave & (src == SRC_QUE);

   // parallel pending mask, a new trigger wins over the clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) par_pend_r <= '0;
      else if (clk_en) begin
         par_pend_r <= (par_pend_r
            & ~((start && !sync_slave && src == SRC_PAR)
                ? ch_bit(src_ch) : '0))
            | (trig ? par_mask : '0); // R3
      end
   end

   // inserted single conversion, leaves other pending requests alone
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ins_pend_r <= 1'b0;
         ins_ch_r   <= '0;
      end else if (clk_en) begin
         if (ins_req) begin
            ins_pend_r <= 1'b1; // R5
            ins_ch_r   <= ins_ch;
         end else if (start && !sync_slave && src == SRC_INS) begin
            ins_pend_r <= 1'b0;
         end
      end
   end

   // request queue in entry order, writes refused while full
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < Q_DEPTH; i++) que_r[i] <= '0;
         q_wp_r  <= '0;
         q_rp_r  <= '0;
         q_cnt_r <= '0;
         q_full  <= 1'b0;
      end else if (clk_en) begin
         if (q_push) begin
            que_r[q_wp_r] <= q_ch; // R4
            q_wp_r        <= q_wp_r + 1'b1;
         end
         if (q_pop) q_rp_r <= q_rp_r + 1'b1;
         q_cnt_r <= q_cnt_r + (q_push ? 1'b1 : 1'b0)
                            - (q_pop ? 1'b1 : 1'b0);
         q_full  <= (q_cnt_r + (q_push ? 1'b1 : 1'b0)
                    - (q_pop ? 1'b1 : 1'b0)) == (QP_W + 1)'(Q_DEPTH);
      end
   end

   // result value in the selected width
   assign res_val = res8_mode ? {2'b00, sar_r[RES_W-1 -: FAST_W]}
                              : sar_r; // R1
   assign sum = acc_sum_r + {2'b00, res_val};
   assign wr_idx = chain_en ? wp_r : ch_r[IDX_W-1:0]; // R8
   assign blocked = wfr_mask[wr_idx] & res_valid[wr_idx]; // R9
   assign finish = (state_r == ST_STORE) & ~blocked;
   assign acc_hold = acc_en & (acc_cnt_r != acc_num); // R10
   assign lim_out = ~lim_en | (res_val < lim_lo) | (res_val > lim_hi);
   assign do_write = finish & ~acc_hold & lim_out; // R10

   // sequencer: wake, sample, approximate, store
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r   <= ST_IDLE;
         cnt_r     <= '0;
         ch_r      <= '0;
         sar_r     <= ZERO_RES;
         bit_r     <= MSB_TRIAL;
         dac_code  <= ZERO_RES;
         sample_en <= 1'b0;
      end else if (clk_en) begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r <= ST_WAKE; // R15
                  ch_r    <= start_ch;
                  // master waits one more cycle for the slave's pulse
                  cnt_r   <= PWRUP_CNT + (sync_master ? 1'b1 : 1'b0);
               end
            end
            ST_WAKE: begin
               if (cnt_r <= 1) begin
                  state_r   <= ST_SAMPLE;
                  sample_en <= 1'b1;
                  cnt_r     <= sample_cycles; // R2
               end else cnt_r <= cnt_r - 1'b1;
            end
            ST_SAMPLE: begin
               if (cnt_r <= 1) begin
                  state_r   <= ST_CONV;
                  sample_en <= 1'b0;
                  sar_r     <= ZERO_RES;
                  bit_r     <= MSB_TRIAL;
                  dac_code  <= MSB_TRIAL;
                  cnt_r     <= step_cycles; // R2
               end else cnt_r <= cnt_r - 1'b1;
            end
            ST_CONV: begin
               if (cnt_r <= 1) begin
                  // keep the trial bit when the input is above it
                  if (cmp_s) sar_r <= dac_code;
                  if (bit_r == (res8_mode ? LSB_8 : LSB_10)) begin // R1
                     state_r  <= ST_STORE;
                     dac_code <= ZERO_RES;
                  end else begin
                     bit_r    <= bit_r >> 1;
                     dac_code <= (cmp_s ? dac_code : sar_r)
                               | (bit_r >> 1);
                     cnt_r    <= step_cycles;
                  end
               end else cnt_r <= cnt_r - 1'b1;
            end
            ST_STORE: begin
               if (!blocked) state_r <= ST_IDLE; // R9
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // status and pin-facing outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy           <= 1'b0;
         powered        <= 1'b0;
         stalled        <= 1'b0;
         ana_sel        <= '0;
         shared_active  <= 1'b0;
         sync_start_out <= 1'b0;
         bwd_precharge  <= 1'b0;
      end else if (clk_en) begin
         busy    <= (state_r != ST_IDLE) | start;
         powered <= (state_r != ST_IDLE) | start; // R15
         stalled <= (state_r == ST_STORE) & blocked; // R9
         if (start) begin
            ana_sel       <= start_ch; // R13
            shared_active <= start_ch >= SHARED_FIRST; // R13
         end else if (finish) shared_active <= 1'b0;
         sync_start_out <= start & sync_master & ~sync_slave; // R11
         bwd_precharge  <= bwd_en
                         & ((start) | (state_r == ST_WAKE && cnt_r > 1));
      end
   end

   // accumulation of successive results
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         acc_sum_r <= ACC_RST;
         acc_cnt_r <= '0;
      end else if (clk_en && finish) begin
         if (acc_hold) begin
            acc_sum_r <= sum; // R10
            acc_cnt_r <= acc_cnt_r + 1'b1;
         end else begin
            acc_sum_r <= ACC_RST;
            acc_cnt_r <= '0;
         end
      end
   end

   // result event, limit report, multiplexer stepping
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         result_evt <= 1'b0;
         limit_hit  <= 1'b0;
         emux_sel   <= EMUX_RST;
      end else if (clk_en) begin
         result_evt <= do_write; // R17
         limit_hit  <= finish & lim_en & lim_out; // R10
         if (finish && emux_en && ch_r == emux_ch) begin
            emux_sel <= (emux_sel == emux_last) ? EMUX_RST
                      : emux_sel + 1'b1; // R12
         end
      end
   end

   // source path checks after each conversion
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_bwd
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) broken_wire[g] <= 1'b0;
            else if (clk_en && finish && bwd_en && ch_r == CH_W'(g))
               broken_wire[g] <= res_val == ZERO_RES; // R16
         end
      end
   endgenerate
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) mux_fault <= 1'b0;
      else if (clk_en && finish && mux_test)
         mux_fault <= (sar_r < MUXT_LO) | (sar_r > MUXT_HI); // R16
   end

   // result slots: write and read pointers plus valid flags
   assign do_read = rd_en & (chain_en ? res_valid[rp_r] : 1'b1);
   assign mem_rd_idx = chain_en ? rp_r : rd_idx;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wp_r      <= '0;
         rp_r      <= '0;
         res_valid <= '0;
         rd_valid  <= 1'b0;
      end else if (clk_en) begin
         if (do_write && chain_en) wp_r <= wp_r + 1'b1; // R8
         if (do_read && chain_en) rp_r <= rp_r + 1'b1;
         rd_valid <= do_read & res_valid[mem_rd_idx];
         for (int i = 0; i < NUM_RES; i++) begin
            // a write in the same cycle as the read keeps the flag set
            if (do_write && wr_idx == IDX_W'(i))
               res_valid[i] <= 1'b1; // R18
            else if (do_read && mem_rd_idx == IDX_W'(i))
               res_valid[i] <= 1'b0; // R18
         end
      end
   end

   result_mem u_mem (
      .clock   (clock),
      .rstn    (rstn),
      .clk_en  (clk_en),
      .wr_en   (do_write),
      .wr_idx  (wr_idx),
      .wr_data ({ch_r, acc_hold ? sum : (acc_en ? sum : {2'b00, res_val})}),
      .rd_en   (do_read),
      .rd_idx  (mem_rd_idx),
      .rd_data (rd_data)
   );
endmodule : adc_request_sequencer
`default_nettype wire

// ---- common/adc_pkg.sv ----
// constants for the converter request sequencer
// assumes a single 50 MHz system clock shared by all core files
package adc_pkg;
   localparam int NUM_CH   = 9;   // seven dedicated plus two shared inputs
   localparam int CH_W     = 4;
   localparam int RES_W    = 10;  // full conversion width
   localparam int FAST_W   = 8;   // fast conversion width
   localparam int ACC_W    = 12;  // room for four summed results
   localparam int NUM_RES  = 8;   // result registers per converter
   localparam int IDX_W    = 3;
   localparam int WORD_W   = CH_W + ACC_W;
   localparam int Q_DEPTH  = 4;   // queued request slots
   localparam int QP_W     = 2;
   localparam int CNT_W    = 8;
   // first channel that both converters can reach
   localparam logic [CH_W-1:0] SHARED_FIRST = 4'h7;
   // wake from power-down before sampling
   localparam int CLK_PERIOD_NS = 20;
   localparam int PWRUP_NS      = 200;
   localparam int PWRUP_CYC     =
      (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] PWRUP_CNT = CNT_W'(PWRUP_CYC);
   // bounds of the multiplexer test mid-scale window
   localparam logic [RES_W-1:0] MUXT_LO = 10'h1f0;
   localparam logic [RES_W-1:0] MUXT_HI = 10'h20f;
   localparam logic [RES_W-1:0] MSB_TRIAL = 10'h200;
   localparam logic [RES_W-1:0] LSB_10 = 10'h001;
   localparam logic [RES_W-1:0] LSB_8  = 10'h004;
   localparam logic [RES_W-1:0] ZERO_RES = 10'h000;
   localparam logic [ACC_W-1:0] ACC_RST = 12'h000;
   localparam logic [2:0] EMUX_RST = 3'h0;
   // sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_WAKE   = 5'b00010,
      ST_SAMPLE = 5'b00100,
      ST_CONV   = 5'b01000,
      ST_STORE  = 5'b10000
   } seq_state_e;
   // request source chosen by arbitration
   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_INS  = 3'b001,
      SRC_PAR  = 3'b010,
      SRC_QUE  = 3'b100
   } src_e;
endpackage : adc_pkg

// ---- core/sync2.sv ----
// two-stage synchroniser for inputs from outside the clock domain
// assumes the stage-one flop feeds only the stage-two flop
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   // two flops in series, frozen with the clock enable
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : sync2
`default_nettype wire

// ---- core/result_mem.sv ----
// eight-word result store with a registered read port
// assumes the caller keeps its own valid flags
`timescale 1ns/1ns
`default_nettype none
module result_mem
   import adc_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic              clk_en,
   input  wire logic              wr_en,
   input  wire logic [IDX_W-1:0]  wr_idx,
   input  wire logic [WORD_W-1:0] wr_data,
   input  wire logic              rd_en,
   input  wire logic [IDX_W-1:0]  rd_idx,
   output logic      [WORD_W-1:0] rd_data
);
   logic [WORD_W-1:0] mem_r [NUM_RES];
   // storage write
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_RES; i++) mem_r[i] <= '0;
      end else if (clk_en && wr_en) begin
         mem_r[wr_idx] <= wr_data;
      end
   end
   // registered read data
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_data <= '0;
      end else if (clk_en && rd_en) begin
         rd_data <= mem_r[rd_idx];
      end
   end
endmodule : result_mem
`default_nettype wire

// ---- tb/analog_src.sv ----
// analog source model: one level per channel and a comparator
// assumes the converter holds its trial code for a few cycles per step
`timescale 1ns/1ns
`default_nettype none
module analog_src (
   input  wire logic       clock,
   input  wire logic       sample_en,
   input  wire logic [3:0] ana_sel,
   input  wire logic [9:0] dac_code,
   input  wire logic [9:0] lvl [9],
   output logic            cmp_pin
);
   logic [9:0] held = 10'h000;
   // track the selected level while sampling, hold it afterwards
   always @(posedge clock) if (sample_en) held <= lvl[ana_sel];
   // comparator: held level at or above trial code
   always_comb cmp_pin = (held >= dac_code);
endmodule : analog_src
`default_nettype wire

// ---- tb/adc_seq_checker.sv ----
// port-level assertions for the request sequencer
// assumes binding to the sequencer top, ports matched by name
`timescale 1ns/1ns
`default_nettype none
module adc_seq_checker
   import adc_pkg::*;
(
   input wire logic clock, rstn, clk_en, busy, powered, sample_en,
   input wire logic result_evt, stalled, rd_en, rd_valid, chain_en,
   input wire logic sync_start_out,
   input wire logic [CNT_W-1:0]   sample_cycles,
   input wire logic [RES_W-1:0]   dac_code,
   input wire logic [IDX_W-1:0]   rd_idx,
   input wire logic [NUM_RES-1:0] res_valid,
   input wire logic [NUM_CH-1:0]  dig_in, dig_dis
);
   logic [CNT_W:0] run_r;
   // length of the current sampling phase
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) run_r <= '0;
      else if (clk_en) run_r <= sample_en ? run_r + 1'h1 : '0;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_samp_len; $fell(sample_en) |-> run_r ==
      {1'h0, (sample_cycles == 8'h00) ? 8'h01 : sample_cycles}; endproperty
   a_samp_len: assert property (p_samp_len) else $error("bad sample len");
   property p_wake; $rose(busy) |-> !sample_en ##[9:12] sample_en; endproperty
   a_wake: assert property (p_wake) else $error("wake timing wrong");
   property p_pwr; (busy || sample_en) |-> powered; endproperty
   a_pwr: assert property (p_pwr) else $error("active while powered down");
   property p_dac; $fell(sample_en) |-> ##[0:1] dac_code == MSB_TRIAL; endproperty
   a_dac: assert property (p_dac) else $error("first trial code wrong");
   property p_evt; result_evt |=> !result_evt; endproperty
   a_evt: assert property (p_evt) else $error("result event too long");
   property p_stall; stalled |-> !result_evt; endproperty
   a_stall: assert property (p_stall) else $error("store while stalled");
   property p_clr; rd_en && !chain_en && !busy && !stalled |=>
      !res_valid[$past(rd_idx)]; endproperty
   a_clr: assert property (p_clr) else $error("valid not cleared");
   property p_rdv; rd_en && !chain_en && res_valid[rd_idx] |=> rd_valid;
   endproperty
   a_rdv: assert property (p_rdv) else $error("read valid missing");
   property p_dig; (dig_in & $past(dig_dis)) == '0; endproperty
   a_dig: assert property (p_dig) else $error("disabled pin seen");
   property p_sync; sync_start_out |=> !sync_start_out; endproperty
   a_sync: assert property (p_sync) else $error("sync start too long");
   c_evt: cover property (result_evt);
   c_stall: cover property (stalled);
   c_rdv: cover property (rd_valid);
   c_sync: cover property (sync_start_out);
endmodule : adc_seq_checker
bind adc_request_sequencer adc_seq_checker chk (.*);
`default_nettype wire

// ---- tb/tb_adc_request_sequencer.sv ----
// self-checking bench for the converter request sequencer
// assumes the analog model answers the comparator from held levels
`timescale 1ns/1ns
`default_nettype none
module tb_adc_request_sequencer;
   import adc_pkg::*;
   logic clock = 1'h0, rstn = 1'h0, clk_en = 1'h1, res8_mode = 1'h0;
   logic sw_trig = 1'h0, int_evt = 1'h0, ext_trig_pin = 1'h0, q_wr = 1'h0;
   logic ins_req = 1'h0, sync_master = 1'h0, sync_slave = 1'h0;
   logic sync_start_in = 1'h0, emux_en = 1'h0, bwd_en = 1'h0;
   logic mux_test = 1'h0, chain_en = 1'h0, lim_en = 1'h0, acc_en = 1'h0;
   logic rd_en = 1'h0, cmp_pin;
   logic [CNT_W-1:0] sample_cycles = 8'h04, step_cycles = 8'h03;
   logic [1:0] trig_sel = 2'h0, prio_ins = 2'h0, prio_par = 2'h0;
   logic [1:0] prio_que = 2'h0, acc_num = 2'h0;
   logic [NUM_CH-1:0] par_mask = '0, pin_in = '0, dig_dis = '0;
   logic [CH_W-1:0] q_ch = '0, ins_ch = '0, slave_ch = '0, emux_ch = '0;
   logic [2:0] emux_last = 3'h0, emux_sel;
   logic [NUM_RES-1:0] wfr_mask = '0, res_valid;
   logic [RES_W-1:0] lim_lo = '0, lim_hi = '0, dac_code;
   logic [IDX_W-1:0] rd_idx = '0;
   logic q_full, busy, powered, sample_en, shared_active, sync_start_out;
   logic bwd_precharge, mux_fault, result_evt, limit_hit, stalled, rd_valid;
   logic [CH_W-1:0] ana_sel, ch;
   logic [NUM_CH-1:0] dig_in, broken_wire;
   logic [WORD_W-1:0] rd_data;
   logic [RES_W-1:0] lvl [NUM_CH] = '{10'h000, 10'h3ff, 10'h155, 10'h2a5,
      10'h0a9, 10'h37c, 10'h1e0, 10'h200, 10'h101};
   int err_total = 0, num_checks = 0;
   adc_request_sequencer dut (.*);
   analog_src src (.*);
   always #10 clock = ~clock;
   task automatic check(input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic pulse(ref logic s);
      s = 1'h1;
      @(posedge clock); #2;
      s = 1'h0;
   endtask : pulse
   // bounded wait for a stored result (sel 0) or a stall (sel 1)
   task automatic wait_for(input logic sel, output logic [3:0] c);
      int n;
      n = 0;
      do begin
         @(posedge clock); #2;
         n++;
         if (n > 400) begin err_total++; report_and_stop; end
      end while ((sel ? stalled : result_evt) !== 1'h1);
      c = ana_sel;
   endtask : wait_for
   // read the register of a channel and compare with its level
   task automatic rd(input logic [3:0] c);
      logic [15:0] exp;
      exp = res8_mode ? {c, 4'h0, lvl[c][9:2]} : {c, 2'h0, lvl[c]};
      rd_idx = c[2:0];
      pulse(rd_en);
      check(rd_valid, 1'h1);
      check(rd_data, exp);
      check(res_valid[c[2:0]], 1'h0);
   endtask : rd
   task automatic t_par;
      check(powered, 1'h0);
      prio_ins = 2'h2; par_mask = 9'h00a;
      pulse(sw_trig);
      repeat (5) @(posedge clock); #2;
      ins_ch = 4'h8;
      pulse(ins_req);
      wait_for(1'h0, ch); check(ch, 4'h1);
      wait_for(1'h0, ch); check(ch, 4'h8);
      wait_for(1'h0, ch); check(ch, 4'h3);
      rd(4'h1); rd(4'h3); rd(4'h8);
      $display("parallel and insert done");
   endtask : t_par
   task automatic t_trig;
      trig_sel = 2'h3; par_mask = 9'h004;
      pulse(int_evt);
      wait_for(1'h0, ch); check(ch, 4'h2);
      par_mask = 9'h010; ext_trig_pin = 1'h1;
      wait_for(1'h0, ch); check(ch, 4'h4);
      ext_trig_pin = 1'h0; trig_sel = 2'h0;
      rd(4'h2); rd(4'h4);
      $display("triggers done");
   endtask : t_trig
   task automatic t_prio;
      prio_que = 2'h3; prio_par = 2'h1; q_ch = 4'h6;
      pulse(q_wr);
      @(posedge clock); #2;
      q_ch = 4'h2; par_mask = 9'h020;
      pulse(q_wr);
      pulse(sw_trig);
      wait_for(1'h0, ch); check(ch, 4'h6);
      wait_for(1'h0, ch); check(ch, 4'h2);
      wait_for(1'h0, ch); check(ch, 4'h5);
      rd(4'h6); rd(4'h2); rd(4'h5);
      $display("priority and queue done");
   endtask : t_prio
   task automatic t_fast;
      res8_mode = 1'h1; sync_master = 1'h1; par_mask = 9'h010;
      pulse(sw_trig);
      wait_for(1'h0, ch); check(ch, 4'h4);
      rd(4'h4);
      res8_mode = 1'h0; sync_master = 1'h0;
      $display("fast mode done");
   endtask : t_fast
   task automatic t_wfr;
      wfr_mask = 8'h40; par_mask = 9'h040;
      pulse(sw_trig);
      wait_for(1'h0, ch);
      pulse(sw_trig);
      wait_for(1'h1, ch); check(res_valid[6], 1'h1);
      rd(4'h6);
      wait_for(1'h0, ch); check(res_valid[6], 1'h1);
      rd(4'h6);
      $display("wait-for-read done");
   endtask : t_wfr
   task automatic t_dig;
      pin_in = 9'h1ff; dig_dis = 9'h0f0;
      repeat (5) @(posedge clock); #2;
      check(dig_in, 9'h10f);
      $display("digital inputs done");
   endtask : t_dig
   initial begin
      repeat (16) @(posedge clock);
      #2 rstn = 1'h1;
      repeat (3) @(posedge clock); #2;
      t_par; t_trig; t_prio; t_fast; t_wfr; t_dig;
      report_and_stop;
   end
endmodule : tb_adc_request_sequencer
`default_nettype wire
